//--- logic/hlpt_pkg.sv
`default_nettype none
package hlpt_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [3:0] CONTROL_OFS = 4'h0;
    localparam logic [3:0] PERIOD_OFS = 4'h1;
    localparam logic [3:0] WIDTH_OFS = 4'h2;
    localparam logic [3:0] COUNT_OFS = 4'h3;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] MASK_OFS = 4'h5;
    localparam logic [3:0] TICK_OFS = 4'h6;

    // ----------------------------------------
    // Control layout
    // ----------------------------------------
    localparam int RUN_BIT = 7;
    localparam int PWM_EN_BIT = 6;
    localparam int CLK_SEL_BIT = 5;
    localparam int MODE_MSB = 4;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    localparam logic [7:0] WIDTH_RESET = 8'h00;
    localparam logic [15:0] TICK_RESET = 16'h0000;

    // ----------------------------------------
    // Modes and events
    // ----------------------------------------
    localparam logic [4:0] MODE_GATED = 5'h00;
    localparam logic [4:0] MODE_ONESHOT_LOW = 5'h0e;
    localparam logic [4:0] MODE_ONESHOT_HIGH = 5'h0f;
    localparam int EV_MATCH = 0;
    localparam int EV_TRIGGER = 1;
    localparam int EV_DONE = 2;
    localparam int EV_COUNT = 3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_COUNT = 2'b10
    } shot_state_t;
endpackage
`default_nettype wire

//--- logic/hlpt_sync.sv
`default_nettype none
// Two-flop synchroniser for one level
module hlpt_sync (
    input wire logic clk,
    input wire logic srst,
    input wire logic din,
    output logic dout
);
    logic stage;

    // Stage then output, nothing reads stage otherwise
    always_ff @(posedge clk) begin
        if (srst) begin
            stage <= 1'b0;
            dout <= 1'b0;
        end else begin
            stage <= din;
            dout <= stage;
        end
    end
endmodule
`default_nettype wire

//--- logic/hw_limit_period_timer.sv
// The implementer's own choices: the register addresses and the plain strobed port.
`default_nettype none
module hw_limit_period_timer (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire logic EXTERNAL_RESET_INPUT,
    input wire logic TIMER_CLOCK_INPUT,
    output logic PWM_OUT,
    output logic POSTSCALED_MATCH_OUT,
    output logic [9:0] TIME_BASE,
    output logic IRQ
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] timer_control_reg;
    logic [7:0] period_value;
    logic [7:0] pulse_width_value;
    logic [7:0] count_value;
    logic [1:0] sub_count;
    logic [15:0] tick_divider;
    logic [15:0] tick_count;
    logic [3:0] status;
    logic [3:0] mask;
    logic ext_sync;
    logic ext_prev;
    logic clk_sync;
    logic clk_prev;
    logic run_sync;
    logic run_prev;
    hlpt_pkg::shot_state_t shot_state;
    hlpt_pkg::shot_state_t next_shot_state;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // External reset level, two flops
    hlpt_sync ext_sync_i (
        .clk(SYS_CLK),
        .srst(SRST),
        .din(EXTERNAL_RESET_INPUT),
        .dout(ext_sync)
    );

    // Tick source pin, two flops
    hlpt_sync clk_sync_i (
        .clk(SYS_CLK),
        .srst(SRST),
        .din(TIMER_CLOCK_INPUT),
        .dout(clk_sync)
    );

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire [4:0] mode = timer_control_reg[hlpt_pkg::MODE_MSB:0];
    wire run = timer_control_reg[hlpt_pkg::RUN_BIT];
    wire pwm_en = timer_control_reg[hlpt_pkg::PWM_EN_BIT];
    wire use_pin_clock = timer_control_reg[hlpt_pkg::CLK_SEL_BIT];
    wire is_low = (mode == hlpt_pkg::MODE_ONESHOT_LOW);
    wire is_high = (mode == hlpt_pkg::MODE_ONESHOT_HIGH);
    wire one_shot = is_low | is_high;
    wire gated = (mode == hlpt_pkg::MODE_GATED);
    // Reset level: low for 01110, high for 01111
    wire at_reset_level = is_high ? ext_sync : ~ext_sync;
    wire prev_reset_level = is_high ? ext_prev : ~ext_prev;
    wire start_edge = one_shot & prev_reset_level & ~at_reset_level;

    // ----------------------------------------
    // Tick source
    // ----------------------------------------
    // Internal tick: divider period from register, or synchronised pin edge
    wire int_tick = (tick_count >= tick_divider); // Shrunk divider cannot stall
    wire pin_tick = clk_sync & ~clk_prev;
    wire tick = use_pin_clock ? pin_tick : int_tick;
    // Run takes effect with a registered copy of the bit for the pin tick source, directly otherwise
    wire run_eff = use_pin_clock ? run_sync : run;

    // Count compares and qualified steps
    wire count_at_period = (count_value == period_value);
    wire count_at_width = (count_value == pulse_width_value);
    wire counting = gated ? run_eff : (shot_state == hlpt_pkg::ST_COUNT);
    wire step = tick & counting;
    wire wrap = step & count_at_period;
    wire shot_match = one_shot & wrap;
    wire width_hit = step & count_at_width;
    // Start edge counts only while armed and running
    wire shot_start = one_shot & run_eff & start_edge & (shot_state == hlpt_pkg::ST_ARMED);

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire wr_ctl = WR & (ADDR == hlpt_pkg::CONTROL_OFS);
    wire wr_per = WR & (ADDR == hlpt_pkg::PERIOD_OFS);
    wire wr_wid = WR & (ADDR == hlpt_pkg::WIDTH_OFS);
    wire wr_sts = WR & (ADDR == hlpt_pkg::STATUS_OFS);
    wire wr_msk = WR & (ADDR == hlpt_pkg::MASK_OFS);
    wire wr_tck = WR & (ADDR == hlpt_pkg::TICK_OFS);
    wire [3:0] events;
    wire [3:0] next_status;
    wire [15:0] read_mux =
        (ADDR == hlpt_pkg::CONTROL_OFS) ? {8'h00, timer_control_reg} :
        (ADDR == hlpt_pkg::PERIOD_OFS) ? {8'h00, period_value} :
        (ADDR == hlpt_pkg::WIDTH_OFS) ? {8'h00, pulse_width_value} :
        (ADDR == hlpt_pkg::COUNT_OFS) ? {8'h00, count_value} :
        (ADDR == hlpt_pkg::STATUS_OFS) ? {12'h000, status} :
        (ADDR == hlpt_pkg::MASK_OFS) ? {12'h000, mask} :
        (ADDR == hlpt_pkg::TICK_OFS) ? tick_divider : 16'h0000;

    // Event vector
    assign events[hlpt_pkg::EV_MATCH] = wrap;
    assign events[hlpt_pkg::EV_TRIGGER] = start_edge & run_eff;
    assign events[hlpt_pkg::EV_DONE] = shot_match;
    assign events[hlpt_pkg::EV_COUNT] = width_hit;

    // Per-event sticky bits, set wins over write-one clear
    for (genvar i = 0; i < $bits(status); i++) begin : g_sticky
        assign next_status[i] = events[i] | (status[i] & ~(wr_sts & WDATA[i]));
    end

    // ----------------------------------------
    // One-shot sequencer
    // ----------------------------------------
    // Idle until run, armed waits for edge, count until match (to idle) or reset level (back to armed)
    always_comb begin
        next_shot_state = shot_state;
        case (shot_state)
            hlpt_pkg::ST_IDLE: begin
                if (one_shot & run & run_eff) begin
                    next_shot_state = hlpt_pkg::ST_ARMED;
                end
            end
            hlpt_pkg::ST_ARMED: begin
                if (~one_shot | ~run_eff) begin
                    next_shot_state = hlpt_pkg::ST_IDLE;
                end else if (start_edge) begin
                    next_shot_state = hlpt_pkg::ST_COUNT;
                end
            end
            hlpt_pkg::ST_COUNT: begin
                if (~one_shot | ~run_eff | shot_match) begin
                    next_shot_state = hlpt_pkg::ST_IDLE;
                end else if (at_reset_level) begin
                    next_shot_state = hlpt_pkg::ST_ARMED;
                end
            end
            default: begin
                next_shot_state = hlpt_pkg::ST_IDLE;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            shot_state <= hlpt_pkg::ST_IDLE;
        end else begin
            shot_state <= next_shot_state;
        end
    end

    // Edge history of the synchronised pins
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ext_prev <= 1'b0;
            clk_prev <= 1'b0;
        end else begin
            ext_prev <= ext_sync;
            clk_prev <= clk_sync;
        end
    end

    // Run bit delayed two cycles for the pin tick source
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            run_prev <= 1'b0;
            run_sync <= 1'b0;
        end else begin
            run_prev <= run;
            run_sync <= run_prev;
        end
    end

    // ----------------------------------------
    // Tick divider
    // ----------------------------------------
    // Instruction-clock style tick from system clock
    always_ff @(posedge SYS_CLK) begin
        if (SRST | int_tick) begin
            tick_count <= hlpt_pkg::TICK_RESET;
        end else begin
            tick_count <= tick_count + 16'h0001;
        end
    end

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    // Count, wrap at period, clear at reset level
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            count_value <= 8'h00;
        end else if (one_shot & (at_reset_level | shot_match)) begin
            count_value <= 8'h00;
        end else if (step) begin
            if (count_at_period) begin
                count_value <= 8'h00;
            end else begin
                count_value <= count_value + 8'h01;
            end
        end
    end

    // Low two bits of ten-bit time base
    always_ff @(posedge SYS_CLK) begin
        if (SRST | wrap | (one_shot & at_reset_level)) begin
            sub_count <= 2'b00;
        end else if (counting) begin
            sub_count <= sub_count + 2'b01;
        end
    end

    // ----------------------------------------
    // Drive output
    // ----------------------------------------
    // On at start edge in one-shot or at period wrap otherwise, off at width or period clear
    always_ff @(posedge SYS_CLK) begin
        if (SRST | ~pwm_en) begin
            PWM_OUT <= 1'b0;
        end else if (one_shot) begin
            if (shot_start) begin
                PWM_OUT <= 1'b1;
            end else if (width_hit | shot_match | at_reset_level) begin
                PWM_OUT <= 1'b0;
            end
        end else if (wrap) begin
            PWM_OUT <= (pulse_width_value != 8'h00);
        end else if (width_hit) begin
            PWM_OUT <= 1'b0;
        end
    end

    // Match pulse at every period wrap
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            POSTSCALED_MATCH_OUT <= 1'b0;
        end else begin
            POSTSCALED_MATCH_OUT <= wrap;
        end
    end

    // Ten-bit time base, count above the sub-count
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            TIME_BASE <= 10'h000;
        end else begin
            TIME_BASE <= {count_value, sub_count};
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Control: software write, hardware clears run on one-shot match
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            timer_control_reg <= hlpt_pkg::CONTROL_RESET;
        end else if (wr_ctl) begin
            timer_control_reg <= WDATA[7:0];
        end else if (shot_match) begin
            timer_control_reg[hlpt_pkg::RUN_BIT] <= 1'b0;
        end
    end

    // Period, width, divider
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            period_value <= hlpt_pkg::PERIOD_RESET;
            pulse_width_value <= hlpt_pkg::WIDTH_RESET;
            tick_divider <= hlpt_pkg::TICK_RESET;
        end else begin
            if (wr_per) begin
                period_value <= WDATA[7:0];
            end
            if (wr_wid) begin
                pulse_width_value <= WDATA[7:0];
            end
            if (wr_tck) begin
                tick_divider <= WDATA;
            end
        end
    end

    // Sticky status, next value from the per-bit terms
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            status <= 4'h0;
        end else begin
            status <= next_status;
        end
    end

    // Interrupt mask
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            mask <= 4'h0;
        end else if (wr_msk) begin
            mask <= WDATA[3:0];
        end
    end

    // Read data, zero outside a read
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            RDATA <= 16'h0000;
        end else begin
            RDATA <= RD ? read_mux : 16'h0000;
        end
    end

    // Level interrupt from unmasked status
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(status & mask);
        end
    end
endmodule
`default_nettype wire

//--- test/hlpt_checker_asserts.sv
`default_nettype none
// ----------------------------------------
// Port checks
// ----------------------------------------
module hlpt_checker (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    input wire logic PWM_OUT,
    input wire logic POSTSCALED_MATCH_OUT,
    input wire logic [9:0] TIME_BASE,
    input wire logic IRQ
);
    logic [7:0] ctl, per, wid, msk;
    wire logic [7:0] c = TIME_BASE[9:2];
    wire logic osh = ctl[4:1] == 4'h7;
    wire logic gated = ctl[4:0] == hlpt_pkg::MODE_GATED;
    // Shadow of written registers
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ctl <= hlpt_pkg::CONTROL_RESET;
            per <= hlpt_pkg::PERIOD_RESET;
            wid <= hlpt_pkg::WIDTH_RESET;
            msk <= 8'h00;
        end else if (WR) begin
            if (ADDR == hlpt_pkg::CONTROL_OFS) ctl <= WDATA[7:0];
            if (ADDR == hlpt_pkg::PERIOD_OFS) per <= WDATA[7:0];
            if (ADDR == hlpt_pkg::WIDTH_OFS) wid <= WDATA[7:0];
            if (ADDR == hlpt_pkg::MASK_OFS) msk <= WDATA[7:0];
        end
    end
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (SRST);
    property p_rd_idle;
        !RD |=> RDATA == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
    property p_rd_unmapped;
        RD && ADDR > 4'h6 |=> RDATA == 16'h0000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    property p_rd_upper;
        RD && ADDR < 4'h6 |=> RDATA[15:8] == 8'h00;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper byte not zero");
    property p_step;
        $changed(c) && c != 8'h00 |-> c == $past(c) + 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("count step not one");
    property p_wrap;
        $changed(c) && $past(c) == $past(per, 2) |-> c == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap to zero");
    property p_hold;
        (gated && !ctl[7]) [*6] |-> $stable(c);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved while stopped");
    property p_pwm_on;
        osh && $rose(PWM_OUT) |-> c <= 8'h01;
    endproperty
    a_pwm_on: assert property (p_pwm_on) else $error("drive on away from start");
    property p_pwm_off;
        osh && $changed(c) && $past(c) == $past(wid, 2) && $past(wid, 2) != 8'h00 |-> !PWM_OUT;
    endproperty
    a_pwm_off: assert property (p_pwm_off) else $error("drive on past width");
    property p_pwm_match;
        osh && $changed(c) && c == 8'h00 && $past(c) == $past(per, 2) |-> ##2 !PWM_OUT [*4];
    endproperty
    a_pwm_match: assert property (p_pwm_match) else $error("drive on after match");
    property p_irq_mask;
        (msk == 8'h00) [*2] |-> !IRQ;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt while masked");
    property p_match_pulse;
        POSTSCALED_MATCH_OUT |=> c == 8'h00;
    endproperty
    a_match_pulse: assert property (p_match_pulse) else $error("match pulse without wrap");
endmodule
bind hw_limit_period_timer hlpt_checker i_chk (.SYS_CLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .PWM_OUT,
    .POSTSCALED_MATCH_OUT, .TIME_BASE, .IRQ);
`default_nettype wire

//--- test/hlpt_far_end.sv
`default_nettype none
// ----------------------------------------
// Trigger source and tick pin
// ----------------------------------------
module hlpt_far_end (
    input wire logic clk,
    input wire logic tick_en,
    input wire logic trig_req,
    output logic ext_pin,
    output logic tick_pin
);
    int unsigned hold = 0;
    logic [2:0] ph = 3'h0;
    initial ext_pin = 1'b0;
    initial tick_pin = 1'b0;
    // Tick every 8 clocks, pin held low when off; trigger levels held long
    always @(posedge clk) begin
        ph <= tick_en ? ph + 3'h1 : 3'h0;
        tick_pin <= tick_en & ph[2];
        if (hold != 0) begin
            hold <= hold - 1;
        end else if (ext_pin != trig_req) begin
            ext_pin <= trig_req;
            hold <= 6;
        end
    end
endmodule
`default_nettype wire

//--- test/tb_hw_limit_period_timer.sv
`default_nettype none
module tb_hw_limit_period_timer;
    timeunit 1ns;
    timeprecision 1ps;
    logic SYS_CLK, SRST, WR, RD, tick_en, trig, lvl;
    logic PWM_OUT, POSTSCALED_MATCH_OUT, IRQ, EXTERNAL_RESET_INPUT, TIMER_CLOCK_INPUT;
    logic [3:0] ADDR;
    logic [15:0] WDATA, RDATA, d;
    logic [9:0] TIME_BASE;
    logic [7:0] per, wid, m;
    int err_total = 0;
    int compares = 0;
    int seed = 58;
    hw_limit_period_timer i_dut (.SYS_CLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .EXTERNAL_RESET_INPUT,
        .TIMER_CLOCK_INPUT, .PWM_OUT, .POSTSCALED_MATCH_OUT, .TIME_BASE, .IRQ);
    hlpt_far_end i_far (.clk(SYS_CLK), .tick_en, .trig_req(trig), .ext_pin(EXTERNAL_RESET_INPUT),
        .tick_pin(TIMER_CLOCK_INPUT));
    // ----------------------------------------
    // Clock, helpers and bus tasks
    // ----------------------------------------
    initial begin
        SYS_CLK = 1'b0;
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end
    function automatic logic [15:0] reset_val(input logic [3:0] a);
        if (a == hlpt_pkg::PERIOD_OFS) return {8'h00, hlpt_pkg::PERIOD_RESET};
        return 16'h0000;
    endfunction
    function automatic logic rst_level(input logic [7:0] mode);
        return mode[4:0] == hlpt_pkg::MODE_ONESHOT_HIGH;
    endfunction
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge SYS_CLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge SYS_CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge SYS_CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge SYS_CLK);
        #1 chk({15'h0000, IRQ}, {15'h0000, e});
    endtask
    // Bounded wait until drive or count equals (ne=0) or leaves (ne=1) v
    task automatic wait_sig(input logic pwm, input logic [7:0] v, input logic ne);
        int n;
        n = 0;
        #1;
        while ((((pwm ? {7'h00, PWM_OUT} : TIME_BASE[9:2]) === v) == ne) && n < 3000) begin
            @(posedge SYS_CLK);
            #1;
            n++;
        end
        if (n == 3000) begin
            err_total++;
            $display("mismatch at %0t: wait ran out", $time);
            stop_test();
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        SRST = 1'b1;
        ADDR = 4'h0;
        WDATA = 16'h0000;
        WR = 1'b0;
        RD = 1'b0;
        tick_en = 1'b0;
        trig = 1'b0;
        repeat (12) @(posedge SYS_CLK);
        SRST <= 1'b0;
        wr(4'h9, 16'hffff);
        for (int a = 0; a < 10; a++) begin
            rd(a[3:0]);
            chk(d, reset_val(a[3:0]));
        end
        $display("test reset done");
        per = 8'h03 + 8'({$random(seed)} % 10);
        wr(hlpt_pkg::TICK_OFS, 16'({$random(seed)} % 4));
        wr(hlpt_pkg::PERIOD_OFS, {8'h00, per});
        wr(hlpt_pkg::MASK_OFS, 16'h0001);
        wr(hlpt_pkg::CONTROL_OFS, 16'h0080);
        wait_sig(1'b0, per, 1'b0);
        wait_sig(1'b0, per, 1'b1);
        chk({8'h00, TIME_BASE[9:2]}, 16'h0000);
        wr(hlpt_pkg::CONTROL_OFS, 16'h0000);
        repeat (8) @(posedge SYS_CLK);
        m = TIME_BASE[9:2];
        repeat (40) @(posedge SYS_CLK);
        chk({8'h00, TIME_BASE[9:2]}, {8'h00, m});
        chk_irq(1'b1);
        wr(hlpt_pkg::MASK_OFS, 16'h0000);
        chk_irq(1'b0);
        wr(hlpt_pkg::MASK_OFS, 16'h0001);
        chk_irq(1'b1);
        wr(hlpt_pkg::STATUS_OFS, 16'h0001);
        chk_irq(1'b0);
        $display("test gated done");
        tick_en <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            m = {3'h0, k ? hlpt_pkg::MODE_ONESHOT_HIGH : hlpt_pkg::MODE_ONESHOT_LOW};
            lvl = rst_level(m);
            per = 8'h04 + 8'({$random(seed)} % 6);
            wid = per >> 1;
            trig <= lvl;
            wr(hlpt_pkg::PERIOD_OFS, {8'h00, per});
            wr(hlpt_pkg::WIDTH_OFS, {8'h00, wid});
            wr(hlpt_pkg::CONTROL_OFS, {8'h00, m | 8'he0});
            repeat (40) @(posedge SYS_CLK);
            chk({8'h00, TIME_BASE[9:2]}, 16'h0000);
            trig <= ~lvl;
            wait_sig(1'b1, 8'h01, 1'b0);
            chk({8'h00, TIME_BASE[9:2]}, 16'h0000);
            wait_sig(1'b1, 8'h00, 1'b0);
            chk({8'h00, TIME_BASE[9:2]}, {8'h00, wid});
            wait_sig(1'b0, per, 1'b0);
            wait_sig(1'b0, per, 1'b1);
            chk({8'h00, TIME_BASE[9:2]}, 16'h0000);
            rd(hlpt_pkg::CONTROL_OFS);
            chk(d & 16'h0080, 16'h0000);
            repeat (60) @(posedge SYS_CLK);
            chk({15'h0000, PWM_OUT}, 16'h0000);
            wr(hlpt_pkg::CONTROL_OFS, {8'h00, m | 8'he0});
            repeat (60) @(posedge SYS_CLK);
            chk({8'h00, TIME_BASE[9:2]}, 16'h0000);
            trig <= lvl;
            repeat (20) @(posedge SYS_CLK);
            trig <= ~lvl;
            wait_sig(1'b1, 8'h01, 1'b0);
            wait_sig(1'b0, 8'h02, 1'b0);
            trig <= lvl;
            repeat (20) @(posedge SYS_CLK);
            chk({7'h00, PWM_OUT, TIME_BASE[9:2]}, 16'h0000);
            wr(hlpt_pkg::CONTROL_OFS, 16'h0000);
            $display("test one-shot mode %h done", m);
        end
        stop_test();
    end
endmodule
`default_nettype wire
